// file: design/egs_cfg.svh
`ifndef EGS_CFG_SVH
`define EGS_CFG_SVH

`define EGS_FUNC_GEAR 16'h0001
`define EGS_FUNC_CAM 16'h0002
`define EGS_IN_PULSE_GEN 4'h0
`define EGS_INTEG_NONE 4'h0
`define EGS_CYCLE_TIME_US 2000
`define EGS_CLK_MHZ 100
`define EGS_CYCLE_CLKS (`EGS_CYCLE_TIME_US * `EGS_CLK_MHZ)
`define EGS_AXES 4
`define EGS_TASKS 2
`define EGS_ACC_FRAC 16

`endif

// file: design/egs_pkg.sv
package egs_pkg;
   typedef enum logic [2:0] {
      EGS_IDLE,
      EGS_RUN,
      EGS_PAUSED,
      EGS_HALTED,
      EGS_CHECK
   } egs_state_t;

   typedef enum logic [1:0] {
      EGS_MODE_STOP,
      EGS_MODE_PASS,
      EGS_MODE_INPOS_OFF
   } egs_opmode_t;
endpackage : egs_pkg

// file: design/egs_gear_supervisor.sv
`timescale 1ns/1ps

`include "egs_cfg.svh"

module egs_gear_supervisor
   import egs_pkg::*;
(
   input wire logic mclk_in, // System clock.
   input wire logic rst_n_in, // Synchronous reset, active low.
   input wire logic cycle_tick_in, // Control cycle strobe.
   input wire logic start_in, // Start gear command pulse.
   input wire logic cancel_in, // Gear/cam cancel command pulse.
   input wire logic opt_end_in, // Optional end command pulse.
   input wire logic forced_end_in, // Forced block end pulse.
   input wire logic pause_in, // Pause request level.
   input wire logic servo_unlock_in, // Servo unlock level.
   input wire logic servo_error_in, // Servo error level.
   input wire logic [1:0] op_mode_in, // Operating mode.
   input wire logic [15:0] func_num_in, // Operand: function number.
   input wire logic [3:0] input_axis_in, // Operand: input axis code.
   input wire logic [3:0] integ_axis_in, // Operand: integrated axis.
   input wire logic [15:0] ratio_num_in, // Operand: ratio numerator.
   input wire logic [15:0] ratio_den_in, // Operand: ratio denominator.
   input wire logic [1:0] op_axis_in, // Operating axis index.
   input wire logic op_task_in, // Owning task.
   input wire logic cam_active_in, // Cam running on operating axis.
   input wire logic [15:0] pulse_gen_delta_in, // Pulse generator count.
   input wire logic pulse_gen_sync_enc_in, // Input is sync encoder.
   input wire logic [15:0] enc_delta_in, // Encoder delta, x4 pulses.
   input wire logic [15:0] axis_delta_in, // Other axis source delta.
   input wire logic [15:0] integ_delta_in, // Integrated axis delta.
   input wire logic limit_cw_in, // Clockwise limit input.
   input wire logic limit_ccw_in, // Counterclockwise limit input.
   input wire logic estop_in, // Emergency stop input.
   input wire logic drv_alarm_in, // Servo driver alarm input.
   input wire logic system_error_in, // System-level error.
   input wire logic [`EGS_TASKS-1:0] task_error_in, // Per task error.
   input wire logic [`EGS_AXES-1:0] axis_error_in, // Per axis error.
   input wire logic soft_limit_set_in, // Software limits configured.
   input wire logic origin_set_in, // Origin established.
   input wire logic [31:0] soft_limit_cw_in, // Clockwise soft limit.
   input wire logic [31:0] soft_limit_ccw_in, // Counterclockwise limit.
   input wire logic [15:0] max_feed_in, // Max pulses per cycle.
   input wire logic [15:0] backlash_in, // Backlash pulses.
   input wire logic in_position_in, // Drive reports in position.
   output logic [15:0] cmd_delta_out, // Command pulses this cycle.
   output logic cmd_valid_out, // Command pulses are live.
   output logic [31:0] cmd_pos_out, // Accumulated command position.
   output logic gear_busy_out, // Axis operating flag.
   output logic pos_done_out, // Positioning completed flag.
   output logic block_advance_out, // Next block may run.
   output logic override_disable_out, // Feed override disabled.
   output logic err_cw_out, // Clockwise overtravel error.
   output logic err_ccw_out, // Counterclockwise overtravel error.
   output logic err_estop_out, // Emergency stop input error.
   output logic err_alarm_out, // Driver alarm input error.
   output logic err_soft_limit_out, // Software limit error.
   output logic err_ratio_ovf_out, // Ratio overflow error.
   output logic err_operand_out, // Bad operand or cam conflict.
   output logic resume_ok_out // Paused gear may continue.
);

   ////////////////////////////////////////////////////////////////////////
   egs_state_t state_q;
   logic [31:0] acc_q;
   logic [31:0] pause_pos_q;
   logic [15:0] backlash_left_q;
   logic dir_neg_q;
   logic [15:0] src_delta;
   logic [31:0] scaled;
   logic signed [31:0] step;
   logic signed [31:0] step_bl;
   logic signed [31:0] next_pos;
   logic [15:0] step_abs;
   logic [`EGS_TASKS-1:0] task_hit;
   logic [`EGS_AXES-1:0] axis_use;
   logic stop_now;
   logic ovf;
   logic soft_hit;
   logic operand_ok;
   logic always_check;
   logic mode_check;

   // Source selection; the pulse generator is input code zero.
   always_comb
   begin
      if (input_axis_in == `EGS_IN_PULSE_GEN)
      begin
         src_delta = pulse_gen_sync_enc_in ? enc_delta_in
                                           : pulse_gen_delta_in;
      end
      else
      begin
         src_delta = axis_delta_in;
      end
   end

   // Only the ratio pair scales the source; unit and pulse rate unused.
   always_comb
   begin
      scaled = $signed(src_delta) * $signed(ratio_num_in);
      step = (ratio_den_in == 16'h0000) ? 32'sh0
           : $signed(scaled) / $signed({16'h0000, ratio_den_in});
      if (integ_axis_in != `EGS_INTEG_NONE)
      begin
         step = step + $signed({{16{integ_delta_in[15]}}, integ_delta_in});
      end
      step_abs = step[31] ? 16'(-step) : step[15:0];
   end

   // Backlash is inserted whenever the gear reverses direction.
   // It is paid out once, on the tick after the reversal is seen.
   always_comb
   begin
      step_bl = step;
      if (backlash_left_q != 16'h0000)
      begin
         step_bl = dir_neg_q ? step - $signed({16'h0000, backlash_left_q})
                             : step + $signed({16'h0000, backlash_left_q});
      end
      next_pos = $signed(acc_q) + step;
   end

   // Overflow and soft limits judge the step this cycle would take.
   assign ovf = (step_abs > max_feed_in);
   assign soft_hit = soft_limit_set_in && origin_set_in &&
      ((next_pos > $signed(soft_limit_cw_in)) ||
       (next_pos < $signed(soft_limit_ccw_in)));

   // Axes this task touches: operating, input and integrated axis.
   genvar gi;
   generate
      for (gi = 0; gi < `EGS_AXES; gi++)
      begin : g_use
         assign axis_use[gi] = (op_axis_in == 2'(gi)) ||
            (input_axis_in == 4'(gi + 1)) ||
            (integ_axis_in == 4'(gi + 1));
      end
      for (gi = 0; gi < `EGS_TASKS; gi++)
      begin : g_task
         assign task_hit[gi] = task_error_in[gi] &&
            (op_task_in == 1'(gi));
      end
   endgenerate

   // Each of these ends motion in the cycle it is seen, with no ramp.
   assign stop_now = limit_cw_in || limit_ccw_in || estop_in ||
      drv_alarm_in || system_error_in || (|task_hit) ||
      (|(axis_error_in & axis_use)) || ovf || soft_hit ||
      servo_error_in || servo_unlock_in || forced_end_in;

   // A start is refused for a wrong function, a busy cam or a zero ratio denominator.
   assign operand_ok = (func_num_in == `EGS_FUNC_GEAR) &&
      !cam_active_in && (ratio_den_in != 16'h0000);

   // Forced end and servo faults seen while running wait for in-position in any mode; pause alone goes to paused.
   assign always_check = forced_end_in || pause_in ||
      servo_error_in || servo_unlock_in;
   assign mode_check = (cancel_in || opt_end_in) &&
      (op_mode_in != EGS_MODE_INPOS_OFF);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= EGS_IDLE;
      end
      else
      begin
         unique case (state_q)
            EGS_IDLE:
            begin
               if (start_in && operand_ok)
               begin
                  state_q <= EGS_RUN;
               end
            end
            EGS_RUN:
            begin
               if (stop_now)
               begin
                  state_q <= always_check ? EGS_CHECK : EGS_HALTED;
               end
               else if (pause_in)
               begin
                  state_q <= EGS_PAUSED;
               end
               else if (cancel_in || opt_end_in)
               begin
                  state_q <= mode_check ? EGS_CHECK : EGS_IDLE;
               end
            end
            EGS_PAUSED:
            begin
               if (stop_now)
               begin
                  state_q <= EGS_HALTED;
               end
               else if (!pause_in && resume_ok_out)
               begin
                  state_q <= EGS_RUN;
               end
               else if (cancel_in)
               begin
                  state_q <= EGS_IDLE;
               end
            end
            EGS_CHECK:
            begin
               if (in_position_in)
               begin
                  state_q <= EGS_IDLE;
               end
            end
            EGS_HALTED:
            begin
               if (cancel_in)
               begin
                  state_q <= EGS_IDLE;
               end
            end
         endcase
      end
   end

   // Valid output is gated combinationally so a stop acts this cycle; the delta clears at the next edge.
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         acc_q <= 32'h0;
         cmd_delta_out <= 16'h0;
         backlash_left_q <= 16'h0;
         dir_neg_q <= 1'b0;
      end
      else if (state_q == EGS_RUN && cycle_tick_in && !stop_now &&
               !pause_in)
      begin
         acc_q <= 32'(next_pos);
         cmd_delta_out <= step_bl[15:0];
         if (step != 32'sh0 && step[31] != dir_neg_q)
         begin
            dir_neg_q <= step[31];
            backlash_left_q <= backlash_in;
         end
         else
         begin
            backlash_left_q <= 16'h0;
         end
      end
      else if (cycle_tick_in || stop_now)
      begin
         cmd_delta_out <= 16'h0;
      end
   end
   assign cmd_pos_out = acc_q;
   assign cmd_valid_out = (state_q == EGS_RUN) && !stop_now &&
      !pause_in;

   // Position at pause is kept; resume only if the axis did not move.
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         pause_pos_q <= 32'h0;
      end
      else if (state_q == EGS_RUN && pause_in)
      begin
         pause_pos_q <= acc_q;
      end
   end
   assign resume_ok_out = (state_q == EGS_PAUSED) &&
      (pause_pos_q == acc_q);

   // Sticky error flags; a new start clears them, except err_operand_out, which takes the start's operand check.
   always_ff @(posedge mclk_in)
   begin
      if (!rst_n_in)
      begin
         err_cw_out <= 1'b0;
         err_ccw_out <= 1'b0;
         err_estop_out <= 1'b0;
         err_alarm_out <= 1'b0;
         err_soft_limit_out <= 1'b0;
         err_ratio_ovf_out <= 1'b0;
         err_operand_out <= 1'b0;
      end
      else if (state_q == EGS_RUN)
      begin
         err_cw_out <= err_cw_out | limit_cw_in;
         err_ccw_out <= err_ccw_out | limit_ccw_in;
         err_estop_out <= err_estop_out | estop_in;
         err_alarm_out <= err_alarm_out | drv_alarm_in;
         err_soft_limit_out <= err_soft_limit_out | soft_hit;
         err_ratio_ovf_out <= err_ratio_ovf_out | ovf;
      end
      else if (state_q == EGS_IDLE && start_in)
      begin
         err_cw_out <= 1'b0;
         err_ccw_out <= 1'b0;
         err_estop_out <= 1'b0;
         err_alarm_out <= 1'b0;
         err_soft_limit_out <= 1'b0;
         err_ratio_ovf_out <= 1'b0;
         err_operand_out <= !operand_ok;
      end
   end

   // Busy covers running and paused, as the axis is still owned.
   assign gear_busy_out = (state_q == EGS_RUN) || (state_q == EGS_PAUSED);
   assign pos_done_out = (state_q == EGS_IDLE);
   assign override_disable_out = gear_busy_out;
   // A gear in stop mode runs forever, so the next block must wait.
   assign block_advance_out = (state_q == EGS_IDLE) ||
      ((op_mode_in != EGS_MODE_STOP) && gear_busy_out);

endmodule : egs_gear_supervisor

// file: test/egs_sup_assertions.sv
`timescale 1ns/1ps
module egs_sup_checker (
   input wire logic mclk_in, // Clock.
   input wire logic rst_n_in, // Reset.
   input wire logic start_in, // Start.
   input wire logic cam_active_in, // Cam on axis.
   input wire logic [15:0] func_num_in, // Function.
   input wire logic limit_cw_in, // Limit.
   input wire logic limit_ccw_in, // Limit.
   input wire logic estop_in, // Stop.
   input wire logic drv_alarm_in, // Alarm.
   input wire logic system_error_in, // Error.
   input wire logic [1:0] task_error_in, // Errors.
   input wire logic [3:0] axis_error_in, // Errors.
   input wire logic [1:0] op_axis_in, // Axis.
   input wire logic op_task_in, // Task.
   input wire logic [1:0] op_mode_in, // Mode.
   input wire logic soft_limit_set_in, // Set.
   input wire logic origin_set_in, // Homed.
   input wire logic [15:0] cmd_delta_out, // Step.
   input wire logic cmd_valid_out, // Live.
   input wire logic gear_busy_out, // Busy.
   input wire logic pos_done_out, // Done.
   input wire logic block_advance_out, // Advance.
   input wire logic override_disable_out, // Override off.
   input wire logic err_estop_out, // Error.
   input wire logic err_alarm_out, // Error.
   input wire logic err_soft_limit_out // Error.
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   limit_halt_a: assert property (
      (limit_cw_in || limit_ccw_in) |-> !cmd_valid_out) else $error("limit");
   estop_err_a: assert property (
      cmd_valid_out ##1 estop_in |=> err_estop_out) else $error("estop");
   alarm_err_a: assert property (
      cmd_valid_out ##1 drv_alarm_in |=> err_alarm_out) else $error("alarm");
   sys_halt_a: assert property (
      system_error_in |-> !cmd_valid_out) else $error("system");
   task_halt_a: assert property (
      task_error_in[op_task_in] |-> !cmd_valid_out) else $error("task");
   axis_halt_a: assert property (
      axis_error_in[op_axis_in] |-> !cmd_valid_out) else $error("axis");
   start_cause_a: assert property (
      $rose(gear_busy_out) && $past(pos_done_out) |-> $past(start_in) &&
      !$past(cam_active_in) && $past(func_num_in) == 16'h0001)
      else $error("start");
   soft_gate_a: assert property (
      $rose(err_soft_limit_out) |->
      $past(soft_limit_set_in) && $past(origin_set_in)) else $error("soft");
   override_off_a: assert property (
      gear_busy_out |-> override_disable_out) else $error("override");
   stop_hold_a: assert property (
      gear_busy_out && op_mode_in == 2'h0 |->
      !block_advance_out && !pos_done_out) else $error("stop mode");
   pulse_cut_a: assert property (
      $fell(cmd_valid_out) && (limit_cw_in || estop_in) |=>
      cmd_delta_out == 16'h0) else $error("pulses");
endmodule : egs_sup_checker
bind egs_gear_supervisor egs_sup_checker u_chk (.mclk_in, .rst_n_in,
   .start_in, .cam_active_in, .func_num_in, .limit_cw_in, .limit_ccw_in,
   .estop_in, .drv_alarm_in, .system_error_in, .task_error_in,
   .axis_error_in, .op_axis_in, .op_task_in, .op_mode_in,
   .soft_limit_set_in, .origin_set_in, .cmd_delta_out, .cmd_valid_out,
   .gear_busy_out, .pos_done_out, .block_advance_out,
   .override_disable_out, .err_estop_out, .err_alarm_out,
   .err_soft_limit_out);

// file: test/egs_servo_model.sv
`timescale 1ns/1ps
module egs_servo_model (
   input wire logic mclk_in, // Clock.
   input wire logic cmd_valid_in, // Pulses live.
   input wire logic [15:0] pg_rate_in, // Generator step.
   input wire logic [15:0] enc_rate_in, // Encoder step.
   input wire logic alarm_req_in, // Raise alarm.
   input wire logic settle_block_in, // Keep hunting.
   output logic [15:0] pulse_gen_delta_out, // Generator delta.
   output logic [15:0] enc_delta_out, // Encoder delta.
   output logic drv_alarm_out, // Driver alarm.
   output logic in_position_out // Settled.
);
   logic [1:0] quiet_q = 2'h0;
   // The drive settles three cycles after the pulses stop.
   always_ff @(posedge mclk_in)
   begin
      if (cmd_valid_in || settle_block_in)
         quiet_q <= 2'h0;
      else if (quiet_q != 2'h3)
         quiet_q <= quiet_q + 2'h1;
   end
   assign in_position_out = (quiet_q == 2'h3) && !settle_block_in;
   assign pulse_gen_delta_out = pg_rate_in;
   assign enc_delta_out = enc_rate_in;
   assign drv_alarm_out = alarm_req_in;
endmodule : egs_servo_model

// file: test/test_egs_gear_supervisor.sv
`timescale 1ns/1ps
module test_egs_gear_supervisor;
   logic mclk_in = 1'b0, rst_n_in, cycle_tick_in, start_in, cancel_in;
   logic opt_end_in, forced_end_in, pause_in, servo_unlock_in;
   logic servo_error_in, op_task_in, cam_active_in, pulse_gen_sync_enc_in;
   logic limit_cw_in, limit_ccw_in, estop_in, drv_alarm_in;
   logic system_error_in, soft_limit_set_in, origin_set_in, in_position_in;
   logic alarm_req, settle_block, cmd_valid_out, gear_busy_out;
   logic pos_done_out, block_advance_out, override_disable_out;
   logic err_cw_out, err_ccw_out, err_estop_out, err_alarm_out;
   logic err_soft_limit_out, err_ratio_ovf_out, err_operand_out;
   logic resume_ok_out;
   logic [1:0] op_mode_in, op_axis_in, task_error_in;
   logic [3:0] input_axis_in, integ_axis_in, axis_error_in;
   logic [15:0] func_num_in, ratio_num_in, ratio_den_in, axis_delta_in;
   logic [15:0] integ_delta_in, max_feed_in, backlash_in, pg_rate;
   logic [15:0] enc_rate, pulse_gen_delta_in, enc_delta_in, cmd_delta_out;
   logic [31:0] soft_limit_cw_in, soft_limit_ccw_in, cmd_pos_out;
   logic [6:0] errv;
   int error_cnt = 0;
   int checks_done = 0;
   assign errv = {err_cw_out, err_ccw_out, err_estop_out, err_alarm_out,
      err_soft_limit_out, err_ratio_ovf_out, err_operand_out};
   egs_gear_supervisor u_dut (.*);
   egs_servo_model u_srv (.mclk_in, .cmd_valid_in(cmd_valid_out),
      .pg_rate_in(pg_rate), .enc_rate_in(enc_rate), .alarm_req_in(alarm_req),
      .settle_block_in(settle_block), .pulse_gen_delta_out(pulse_gen_delta_in),
      .enc_delta_out(enc_delta_in), .drv_alarm_out(drv_alarm_in),
      .in_position_out(in_position_in));
   always #5 mclk_in = ~mclk_in;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse(ref logic s);
      @(negedge mclk_in) s = 1'b1;
      @(negedge mclk_in) s = 1'b0;
   endtask : pulse
   task automatic idle_wait;
      int n = 0;
      while (pos_done_out !== 1'b1 && n < 60)
      begin
         @(negedge mclk_in);
         n++;
      end
      chk(16'(pos_done_out), 16'h1);
   endtask : idle_wait
   task end_sim;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   initial
   begin
      #300000;
      error_cnt++;
      end_sim();
   end
   initial
   begin
      {rst_n_in, cycle_tick_in, start_in, cancel_in, opt_end_in} = '0;
      {forced_end_in, pause_in, servo_unlock_in, servo_error_in} = '0;
      {op_task_in, cam_active_in, pulse_gen_sync_enc_in, limit_cw_in} = '0;
      {limit_ccw_in, estop_in, system_error_in, soft_limit_set_in} = '0;
      {origin_set_in, alarm_req, settle_block, op_mode_in} = '0;
      {op_axis_in, task_error_in, input_axis_in, integ_axis_in} = '0;
      {axis_error_in, axis_delta_in, integ_delta_in, backlash_in} = '0;
      func_num_in = 16'h0001;
      ratio_num_in = 16'h0001;
      ratio_den_in = 16'h0001;
      max_feed_in = 16'h0100;
      soft_limit_cw_in = 32'h0000_1000;
      soft_limit_ccw_in = 32'hffff_0000;
      pg_rate = 16'h0004;
      enc_rate = 16'hfffe;
      repeat (5) @(negedge mclk_in);
      rst_n_in = 1'b1;
      chk(16'({gear_busy_out, pos_done_out, block_advance_out}), 16'h3);
      pulse(start_in);
      chk(16'({gear_busy_out, override_disable_out, pos_done_out,
         block_advance_out}), 16'hc);
      pulse(cycle_tick_in);
      chk(cmd_delta_out, 16'h0004);
      backlash_in = 16'h0003;
      pulse_gen_sync_enc_in = 1'b1;
      pulse(cycle_tick_in);
      chk(cmd_delta_out, 16'hfffe);
      pulse(cycle_tick_in);
      chk(cmd_delta_out, 16'hfffb);
      chk(cmd_pos_out[15:0], 16'h0000);
      pulse_gen_sync_enc_in = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         pulse(cancel_in);
         idle_wait();
         pulse(start_in);
         @(negedge mclk_in);
         case (i)
            0: limit_cw_in = 1'b1;
            1: limit_ccw_in = 1'b1;
            2: estop_in = 1'b1;
            3: alarm_req = 1'b1;
            4: system_error_in = 1'b1;
            5: task_error_in = 2'h1;
            6: axis_error_in = 4'h1;
            default: ratio_num_in = 16'h0064;
         endcase
         if (i == 7)
            pulse(cycle_tick_in);
         else
            #1 chk(16'(cmd_valid_out), 16'h0);
         @(negedge mclk_in);
         chk(16'(errv), (i < 4) ? 16'h40 >> i : (i == 7) ? 16'h2 : 16'h0);
         {limit_cw_in, limit_ccw_in, estop_in, alarm_req} = '0;
         {system_error_in, task_error_in, axis_error_in} = '0;
         ratio_num_in = 16'h0001;
      end
      pulse(cancel_in);
      idle_wait();
      soft_limit_cw_in = 32'h0000_0002;
      soft_limit_set_in = 1'b1;
      pulse(start_in);
      repeat (2) pulse(cycle_tick_in);
      chk(16'(err_soft_limit_out), 16'h0);
      origin_set_in = 1'b1;
      pulse(cycle_tick_in);
      @(negedge mclk_in);
      chk(16'(err_soft_limit_out), 16'h1);
      soft_limit_set_in = 1'b0;
      pulse(cancel_in);
      idle_wait();
      cam_active_in = 1'b1;
      pulse(start_in);
      chk(16'({gear_busy_out, err_operand_out}), 16'h1);
      cam_active_in = 1'b0;
      func_num_in = 16'h0002;
      pulse(start_in);
      chk(16'({gear_busy_out, err_operand_out}), 16'h1);
      func_num_in = 16'h0001;
      settle_block = 1'b1;
      pulse(start_in);
      pulse(cancel_in);
      repeat (5) @(negedge mclk_in);
      chk(16'(pos_done_out), 16'h0);
      settle_block = 1'b0;
      idle_wait();
      op_mode_in = 2'h2;
      settle_block = 1'b1;
      pulse(start_in);
      pulse(cancel_in);
      @(negedge mclk_in);
      chk(16'(pos_done_out), 16'h1);
      pulse(start_in);
      pause_in = 1'b1;
      #1 chk(16'(cmd_valid_out), 16'h0);
      chk(16'(block_advance_out), 16'h1);
      @(negedge mclk_in);
      chk(16'({gear_busy_out, resume_ok_out}), 16'h3);
      pause_in = 1'b0;
      pulse(forced_end_in);
      repeat (5) @(negedge mclk_in);
      chk(16'(pos_done_out), 16'h0);
      settle_block = 1'b0;
      idle_wait();
      op_mode_in = 2'h1;
      pulse(start_in);
      chk(16'({gear_busy_out, block_advance_out}), 16'h3);
      pulse(opt_end_in);
      chk(16'(pos_done_out), 16'h0);
      idle_wait();
      op_mode_in = 2'h2;
      for (int j = 0; j < 2; j++)
      begin
         pulse(start_in);
         if (j == 0)
            servo_unlock_in = 1'b1;
         else
            servo_error_in = 1'b1;
         #1 chk(16'(cmd_valid_out), 16'h0);
         @(negedge mclk_in);
         {servo_unlock_in, servo_error_in} = '0;
         chk(16'(pos_done_out), 16'h0);
         idle_wait();
      end
      {input_axis_in, integ_axis_in} = 8'h12;
      {axis_delta_in, integ_delta_in} = {16'h0006, 16'h0001};
      {ratio_num_in, ratio_den_in} = {16'h0002, 16'h0003};
      pulse(start_in);
      pulse(cycle_tick_in);
      chk(cmd_delta_out, 16'h0005);
      axis_error_in = 4'h2;
      #1 chk(16'(cmd_valid_out), 16'h0);
      end_sim();
   end
endmodule : test_egs_gear_supervisor
